// >>> core/scec_map.vh
// Functional notes
// - Transmit-end request only while its enable bit is 1, else suppressed.
// - Multiprocessor enable 1 blocks receive requests and flag updates until a marked frame.
// - A frame whose multiprocessor bit is 1 clears the multiprocessor enable itself.
// - Multiprocessor enable 0 gives normal reception, every frame updates flags and requests.
// - Receive enable 0 stops reception and leaves the receive pin as port pin.
// - Receive enable 1 starts reception and routes the receive pin as serial data.
// - Transmit enable 1 starts transmission and drives the transmit pin serially.
// - Receive-full and receive-error requests only while receive interrupt enable is 1.
`ifndef SCEC_MAP_VH
`define SCEC_MAP_VH

// Register byte addresses.
`define SCEC_ADDR_CTRL     5'h00
`define SCEC_ADDR_STATUS   5'h04
`define SCEC_ADDR_IRQ_STAT 5'h08
`define SCEC_ADDR_IRQ_CLR  5'h0c
`define SCEC_ADDR_IRQ_EN   5'h10
`define SCEC_ADDR_FLAG_CLR 5'h14
`define SCEC_ADDR_W        5

// Control register fields.
`define SCEC_CTRL_TX_END_IE 0
`define SCEC_CTRL_MP_IE     1
`define SCEC_CTRL_RX_EN     2
`define SCEC_CTRL_TX_EN     3
`define SCEC_CTRL_RX_IE     4
`define SCEC_CTRL_TX_IE     5
`define SCEC_CTRL_W         6
`define SCEC_CTRL_RESET     6'h00

// Status register fields.
`define SCEC_ST_RX_FULL     0
`define SCEC_ST_FRAMING     1
`define SCEC_ST_OVERRUN     2
`define SCEC_ST_RX_PIN      3
`define SCEC_ST_W           4
`define SCEC_FLAG_W         3
`define SCEC_FLAG_RESET     3'h0

// Interrupt status, clear and enable fields.
`define SCEC_EV_ACCEPT      0
`define SCEC_EV_ERROR       1
`define SCEC_EV_TX_END      2
`define SCEC_EV_MP_MATCH    3
`define SCEC_EV_W           4
`define SCEC_EV_RESET       4'h0

// Bus answers.
`define SCEC_RESP_OKAY      2'h0
`define SCEC_RESP_SLVERR    2'h2
`define SCEC_DATA_W         32

`endif

// >>> core/scec_irq_gate.v
`timescale 1ns/1ps
`default_nettype none
`include "scec_map.vh"

// Gates the four unit interrupt requests by their enable bits.
module scec_irq_gate (
  input  wire aclk,
  input  wire aresetn,
  input  wire ce,
  input  wire tx_end_ie,
  input  wire mp_ie,
  input  wire rx_ie,
  input  wire tx_ie,
  input  wire rx_full_flag,
  input  wire error_any,
  input  wire tx_end,
  input  wire tx_data_empty,
  output reg  tx_end_irq,
  output reg  rx_full_irq,
  output reg  rx_error_irq,
  output reg  tx_empty_irq
);

  wire rx_allow;

  // Receive requests need the receive interrupt enable and no pending address hunt.
  assign rx_allow = rx_ie & ~mp_ie;

  // Requests are registered so they never glitch on the way out.
  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_end_irq   <= 1'b0;
      rx_full_irq  <= 1'b0;
      rx_error_irq <= 1'b0;
      tx_empty_irq <= 1'b0;
    end else if (ce) begin
      tx_end_irq   <= tx_end & tx_end_ie;
      rx_full_irq  <= rx_full_flag & rx_allow;
      rx_error_irq <= error_any & rx_allow;
      tx_empty_irq <= tx_data_empty & tx_ie;
    end
  end

endmodule // scec_irq_gate
`default_nettype wire

// >>> core/scec_top.v
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "scec_map.vh"

// Control-bit logic of the serial unit with an AXI4-Lite register port.
module scec_top (
  input  wire                         aclk,
  input  wire                         aresetn,
  input  wire                         ce,
  // AXI4-Lite slave.
  input  wire [`SCEC_ADDR_W-1:0]      s_axi_awaddr,
  input  wire                         s_axi_awvalid,
  output wire                         s_axi_awready,
  input  wire [`SCEC_DATA_W-1:0]      s_axi_wdata,
  input  wire [3:0]                   s_axi_wstrb,
  input  wire                         s_axi_wvalid,
  output wire                         s_axi_wready,
  output reg  [1:0]                   s_axi_bresp,
  output reg                          s_axi_bvalid,
  input  wire                         s_axi_bready,
  input  wire [`SCEC_ADDR_W-1:0]      s_axi_araddr,
  input  wire                         s_axi_arvalid,
  output wire                         s_axi_arready,
  output reg  [`SCEC_DATA_W-1:0]      s_axi_rdata,
  output reg  [1:0]                   s_axi_rresp,
  output reg                          s_axi_rvalid,
  input  wire                         s_axi_rready,
  // Receive datapath events, same clock.
  input  wire                         rx_frame_done,
  input  wire                         rx_frame_mp_bit,
  input  wire                         rx_frame_ferr,
  // Transmit datapath state, same clock.
  input  wire                         tx_serial_data,
  input  wire                         tx_end,
  input  wire                         tx_data_empty,
  // Port function of the pins.
  input  wire                         port_tx_data,
  input  wire                         port_tx_oe_n,
  output reg                          port_rx_data,
  // Pins.
  input  wire                         rx_pin,
  output reg                          tx_pin_o,
  output reg                          tx_pin_oe_n,
  // Datapath controls and sampled data.
  output reg                          rx_serial_data,
  output wire                         rx_enable,
  output wire                         tx_enable,
  // Interrupt requests.
  output wire                         tx_end_irq,
  output wire                         rx_full_irq,
  output wire                         rx_error_irq,
  output wire                         tx_empty_irq,
  output reg                          irq
);

  reg  [`SCEC_CTRL_W-1:0] ctrl_q;
  reg  [`SCEC_FLAG_W-1:0] flag_q;
  reg  [`SCEC_EV_W-1:0]   ev_stat_q;
  reg  [`SCEC_EV_W-1:0]   ev_en_q;
  reg                     rx_meta_q;
  reg                     rx_sync_q;
  reg                     tx_end_q;
  reg                     aw_got_q;
  reg                     w_got_q;
  reg  [`SCEC_ADDR_W-1:0] awaddr_q;
  reg  [`SCEC_DATA_W-1:0] wdata_q;
  reg                     wlane_q;
  wire                    wr_fire;
  wire [`SCEC_ADDR_W-1:0] wr_addr;
  wire [`SCEC_DATA_W-1:0] wr_data;
  wire                    wr_lane;
  wire                    frame_in;
  wire                    mp_match;
  wire                    accept;
  wire                    set_full;
  wire                    set_ferr;
  wire                    set_oerr;
  wire                    tx_end_rise;
  reg                     wr_ctrl;
  reg                     wr_ev_clr;
  reg                     wr_ev_en;
  reg                     wr_flag_clr;
  reg                     wr_ok;
  reg  [`SCEC_FLAG_W-1:0] flag_d;
  reg  [`SCEC_EV_W-1:0]   ev_set;
  reg  [`SCEC_EV_W-1:0]   ev_stat_d;
  reg  [`SCEC_CTRL_W-1:0] ctrl_d;
  reg  [`SCEC_DATA_W-1:0] rd_data;
  reg                     rd_ok;

  assign rx_enable = ctrl_q[`SCEC_CTRL_RX_EN];
  assign tx_enable = ctrl_q[`SCEC_CTRL_TX_EN];

  // Two flops bring the asynchronous receive pin into the clock domain.
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
    end else if (ce) begin
      rx_meta_q <= rx_pin;
      rx_sync_q <= rx_meta_q;
    end
  end

  // Pin routing: serial function when enabled, port function otherwise.
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_serial_data <= 1'b1;
      port_rx_data   <= 1'b1;
      tx_pin_o       <= 1'b1;
      tx_pin_oe_n    <= 1'b1;
    end else if (ce) begin
      if (rx_enable) begin
        rx_serial_data <= rx_sync_q;
        port_rx_data   <= 1'b1;
      end else begin
        rx_serial_data <= 1'b1; // Line idles high to the receiver.
        port_rx_data   <= rx_sync_q;
      end
      if (tx_enable) begin
        tx_pin_o    <= tx_serial_data;
        tx_pin_oe_n <= 1'b0;
      end else begin
        tx_pin_o    <= port_tx_data;
        tx_pin_oe_n <= port_tx_oe_n;
      end
    end
  end

  // A frame counts only while reception is on; the hunt filters the rest.
  assign frame_in = rx_frame_done & rx_enable;
  assign mp_match = frame_in & rx_frame_mp_bit;
  assign accept   = frame_in &
                    (~ctrl_q[`SCEC_CTRL_MP_IE] | rx_frame_mp_bit);
  assign set_full = accept;
  assign set_ferr = accept & rx_frame_ferr;
  assign set_oerr = accept & flag_q[`SCEC_ST_RX_FULL];
  assign tx_end_rise = tx_end & ~tx_end_q;

  // Write side of the bus: address and data are taken in either order.
  // Readies stay low while the clock enable is low, so no beat is lost.
  assign s_axi_awready = ce & ~aw_got_q & ~s_axi_bvalid;
  assign s_axi_wready  = ce & ~w_got_q & ~s_axi_bvalid;
  assign wr_addr = aw_got_q ? awaddr_q : s_axi_awaddr;
  assign wr_data = w_got_q ? wdata_q : s_axi_wdata;
  assign wr_lane = w_got_q ? wlane_q : s_axi_wstrb[0];
  assign wr_fire = ce & ~s_axi_bvalid &
                   (aw_got_q | s_axi_awvalid) & (w_got_q | s_axi_wvalid);

  // Write address decode; only byte lane 0 carries register bits.
  always @* begin
    wr_ctrl     = 1'b0;
    wr_ev_clr   = 1'b0;
    wr_ev_en    = 1'b0;
    wr_flag_clr = 1'b0;
    wr_ok       = 1'b1;
    if (wr_addr == `SCEC_ADDR_CTRL) begin
      wr_ctrl = wr_fire & wr_lane;
    end else if (wr_addr == `SCEC_ADDR_IRQ_CLR) begin
      wr_ev_clr = wr_fire & wr_lane;
    end else if (wr_addr == `SCEC_ADDR_IRQ_EN) begin
      wr_ev_en = wr_fire & wr_lane;
    end else if (wr_addr == `SCEC_ADDR_FLAG_CLR) begin
      wr_flag_clr = wr_fire & wr_lane;
    end else if (wr_addr == `SCEC_ADDR_STATUS ||
                 wr_addr == `SCEC_ADDR_IRQ_STAT) begin
      wr_ok = 1'b1; // Read-only registers ignore the write.
    end else begin
      wr_ok = 1'b0;
    end
  end

  // Write channel bookkeeping and the response.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q     <= 1'b0;
      w_got_q      <= 1'b0;
      awaddr_q     <= {`SCEC_ADDR_W{1'b0}};
      wdata_q      <= {`SCEC_DATA_W{1'b0}};
      wlane_q      <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SCEC_RESP_OKAY;
    end else if (ce) begin
      if (wr_fire) begin
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `SCEC_RESP_OKAY : `SCEC_RESP_SLVERR;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_got_q <= 1'b1;
          awaddr_q <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_got_q <= 1'b1;
          wdata_q <= s_axi_wdata;
          wlane_q <= s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // Control next value: the hunt bit drops by itself on a marked frame.
  always @* begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = wr_data[`SCEC_CTRL_W-1:0];
    end
    if (mp_match) begin
      ctrl_d[`SCEC_CTRL_MP_IE] = 1'b0;
    end
  end

  // Receive flags: hardware setting wins over a clear in the same cycle.
  always @* begin
    flag_d = flag_q;
    if (wr_flag_clr) begin
      flag_d = flag_q & ~wr_data[`SCEC_FLAG_W-1:0];
    end
    if (set_full) begin
      flag_d[`SCEC_ST_RX_FULL] = 1'b1;
    end
    if (set_ferr) begin
      flag_d[`SCEC_ST_FRAMING] = 1'b1;
    end
    if (set_oerr) begin
      flag_d[`SCEC_ST_OVERRUN] = 1'b1;
    end
  end

  // Sticky event bits: set wins over the write-one clear.
  always @* begin
    ev_set = {`SCEC_EV_W{1'b0}};
    ev_set[`SCEC_EV_ACCEPT]   = accept;
    ev_set[`SCEC_EV_ERROR]    = set_ferr | set_oerr;
    ev_set[`SCEC_EV_TX_END]   = tx_end_rise;
    ev_set[`SCEC_EV_MP_MATCH] = mp_match;
    ev_stat_d = ev_stat_q;
    if (wr_ev_clr) begin
      ev_stat_d = ev_stat_q & ~wr_data[`SCEC_EV_W-1:0];
    end
    ev_stat_d = ev_stat_d | ev_set;
  end

  // State registers of the control block.
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q    <= `SCEC_CTRL_RESET;
      flag_q    <= `SCEC_FLAG_RESET;
      ev_stat_q <= `SCEC_EV_RESET;
      ev_en_q   <= `SCEC_EV_RESET;
      tx_end_q  <= 1'b0;
      irq       <= 1'b0;
    end else if (ce) begin
      ctrl_q    <= ctrl_d;
      flag_q    <= flag_d;
      ev_stat_q <= ev_stat_d;
      tx_end_q  <= tx_end;
      if (wr_ev_en) begin
        ev_en_q <= wr_data[`SCEC_EV_W-1:0];
      end
      irq <= |(ev_stat_q & ev_en_q);
    end
  end

  // Read address decode.
  always @* begin
    rd_data = {`SCEC_DATA_W{1'b0}};
    rd_ok   = 1'b1;
    if (s_axi_araddr == `SCEC_ADDR_CTRL) begin
      rd_data[`SCEC_CTRL_W-1:0] = ctrl_q;
    end else if (s_axi_araddr == `SCEC_ADDR_STATUS) begin
      rd_data[`SCEC_FLAG_W-1:0] = flag_q;
      rd_data[`SCEC_ST_RX_PIN]  = rx_sync_q;
    end else if (s_axi_araddr == `SCEC_ADDR_IRQ_STAT) begin
      rd_data[`SCEC_EV_W-1:0] = ev_stat_q;
    end else if (s_axi_araddr == `SCEC_ADDR_IRQ_EN) begin
      rd_data[`SCEC_EV_W-1:0] = ev_en_q;
    end else if (s_axi_araddr == `SCEC_ADDR_IRQ_CLR ||
                 s_axi_araddr == `SCEC_ADDR_FLAG_CLR) begin
      rd_ok = 1'b1; // Write-only registers read as zero.
    end else begin
      rd_ok = 1'b0;
    end
  end

  // Read channel: one read in flight, answered the cycle after it is taken.
  assign s_axi_arready = ce & ~s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= {`SCEC_DATA_W{1'b0}};
      s_axi_rresp  <= `SCEC_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_data;
        s_axi_rresp  <= rd_ok ? `SCEC_RESP_OKAY : `SCEC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Request gating by the enable bits.
  scec_irq_gate u_gate (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .ce            (ce),
    .tx_end_ie     (ctrl_q[`SCEC_CTRL_TX_END_IE]),
    .mp_ie         (ctrl_q[`SCEC_CTRL_MP_IE]),
    .rx_ie         (ctrl_q[`SCEC_CTRL_RX_IE]),
    .tx_ie         (ctrl_q[`SCEC_CTRL_TX_IE]),
    .rx_full_flag  (flag_q[`SCEC_ST_RX_FULL]),
    .error_any     (flag_q[`SCEC_ST_FRAMING] | flag_q[`SCEC_ST_OVERRUN]),
    .tx_end        (tx_end),
    .tx_data_empty (tx_data_empty),
    .tx_end_irq    (tx_end_irq),
    .rx_full_irq   (rx_full_irq),
    .rx_error_irq  (rx_error_irq),
    .tx_empty_irq  (tx_empty_irq)
  );

endmodule // scec_top
`default_nettype wire

// >>> test/scec_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// Checks the pin routing and the gating of the transmit requests.
module scec_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic rx_pin,
  input wire logic rx_enable,
  input wire logic rx_serial_data,
  input wire logic port_rx_data,
  input wire logic tx_enable,
  input wire logic tx_serial_data,
  input wire logic port_tx_data,
  input wire logic port_tx_oe_n,
  input wire logic tx_pin_o,
  input wire logic tx_pin_oe_n,
  input wire logic tx_end,
  input wire logic tx_end_irq,
  input wire logic tx_data_empty,
  input wire logic tx_empty_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // A low receive pin held past the synchroniser, reception on or off.
  sequence rx_low_on;
    (rx_enable && !rx_pin)[*4];
  endsequence
  sequence rx_low_off;
    (!rx_enable && !rx_pin)[*4];
  endsequence
  AST_RX_OFF_PIN: assert property (rx_low_off |-> rx_serial_data && !port_rx_data)
    else $error("receive pin not left to the port");
  AST_RX_ON_PIN: assert property (rx_low_on |-> !rx_serial_data && port_rx_data)
    else $error("receive pin not routed to the receiver");
  AST_TX_ON_PIN: assert property (tx_enable |=> !tx_pin_oe_n &&
    tx_pin_o == $past(tx_serial_data)) else $error("transmit pin not serial");
  AST_TX_OFF_PIN: assert property (!tx_enable |=> tx_pin_o == $past(port_tx_data)
    && tx_pin_oe_n == $past(port_tx_oe_n)) else $error("transmit pin not port");
  AST_TX_END_GATE: assert property (tx_end_irq |-> $past(tx_end))
    else $error("transmit-end request without its cause");
  AST_TX_END_DROP: assert property ($fell(tx_end) |=> !tx_end_irq)
    else $error("transmit-end request outlived its cause");
  AST_TX_EMPTY_GATE: assert property (tx_empty_irq |-> $past(tx_data_empty))
    else $error("transmit-empty request without its cause");
  AST_TX_EMPTY_DROP: assert property ($fell(tx_data_empty) |=> !tx_empty_irq)
    else $error("transmit-empty request outlived its cause");
endmodule // scec_asserts

bind scec_top scec_asserts u_chk (.*);
`default_nettype wire

// >>> test/scec_station.sv
`timescale 1ns/1ps
`default_nettype none
// Remote station: one frame event per request, pin level on demand.
module scec_station (
  input  wire logic aclk,
  input  wire logic st_go,
  input  wire logic st_mp,
  input  wire logic st_fe,
  input  wire logic st_lvl,
  output var  logic rx_frame_done,
  output var  logic rx_frame_mp_bit,
  output var  logic rx_frame_ferr,
  output var  logic rx_pin
);
  initial begin
    rx_frame_done = 1'h0;
    rx_frame_mp_bit = 1'h0;
    rx_frame_ferr = 1'h0;
    rx_pin = 1'h1;
  end
  // Side bits flip between frames so that stale values are never trusted.
  always @(posedge aclk) begin
    rx_frame_done <= st_go;
    rx_frame_mp_bit <= st_go ? st_mp : ~rx_frame_mp_bit;
    rx_frame_ferr <= st_go ? st_fe : ~rx_frame_ferr;
    rx_pin <= st_lvl;
  end
endmodule // scec_station
`default_nettype wire

// >>> test/serial_ctrl_enable_bits_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "scec_map.vh"
module serial_ctrl_enable_bits_bench;
  logic aclk = 1'h0, aresetn = 1'h0, ce = 1'h1;
  logic [4:0] s_axi_awaddr = 5'h0, s_axi_araddr = 5'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, rx_frame_done, rx_frame_mp_bit, rx_frame_ferr;
  logic tx_serial_data = 1'h0, tx_end = 1'h0, tx_data_empty = 1'h0;
  logic port_tx_data = 1'h1, port_tx_oe_n = 1'h1;
  logic st_go = 1'h0, st_mp = 1'h0, st_fe = 1'h0, st_lvl = 1'h1;
  logic rx_pin, port_rx_data, tx_pin_o, tx_pin_oe_n, rx_serial_data;
  logic rx_enable, tx_enable, tx_end_irq, rx_full_irq, rx_error_irq;
  logic tx_empty_irq, irq;
  int fails = 0, cmp_count = 0;
  localparam logic [31:0] TEIE = 32'h1 << `SCEC_CTRL_TX_END_IE;
  localparam logic [31:0] MPIE = 32'h1 << `SCEC_CTRL_MP_IE;
  localparam logic [31:0] RXEN = 32'h1 << `SCEC_CTRL_RX_EN;
  localparam logic [31:0] TXEN = 32'h1 << `SCEC_CTRL_TX_EN;
  localparam logic [31:0] RXIE = 32'h1 << `SCEC_CTRL_RX_IE;
  localparam logic [31:0] TXIE = 32'h1 << `SCEC_CTRL_TX_IE;
  localparam logic [31:0] EV_TE = 32'h1 << `SCEC_EV_TX_END;

  scec_top uut (.*);
  scec_station u_station (.*);

  // Clock and watchdog.
  always #50 aclk = ~aclk;
  initial begin
    #(100 * 20000);
    fails++;
    tally_and_finish();
  end

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t saw %h, wanted %h", $time, got, exp);
    end
  endtask

  // Writes one word; each channel is released at the edge that takes it.
  task automatic wr(input logic [4:0] a, input logic [31:0] d,
                    input logic [1:0] r = `SCEC_RESP_OKAY);
    logic da, dw;
    da = 1'h0;
    dw = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(negedge aclk);
      if (s_axi_awvalid && s_axi_awready) da = 1'h1;
      if (s_axi_wvalid && s_axi_wready) dw = 1'h1;
      @(posedge aclk);
      if (da) s_axi_awvalid <= 1'h0;
      if (dw) s_axi_wvalid <= 1'h0;
    end while (!(da && dw));
    do @(negedge aclk); while (!s_axi_bvalid);
    chk(s_axi_bresp, r);
    @(posedge aclk);
    s_axi_bready <= 1'h0;
  endtask

  // Reads one word and compares data and response.
  task automatic rd(input logic [4:0] a, input logic [31:0] e,
                    input logic [1:0] r = `SCEC_RESP_OKAY);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'h0;
    do @(negedge aclk); while (!s_axi_rvalid);
    chk(s_axi_rdata, e);
    chk(s_axi_rresp, r);
    @(posedge aclk);
    s_axi_rready <= 1'h0;
  endtask

  // Has the station deliver one frame, then lets the results settle.
  task automatic frame(input logic m, input logic f);
    @(posedge aclk);
    st_go <= 1'h1;
    st_mp <= m;
    st_fe <= f;
    @(posedge aclk);
    st_go <= 1'h0;
    repeat (4) @(posedge aclk);
  endtask

  // Reset state, unmapped places and the port or serial use of the pins.
  task automatic t_pins();
    rd(`SCEC_ADDR_CTRL, 32'h0);
    rd(5'h18, 32'h0, `SCEC_RESP_SLVERR);
    wr(5'h1c, 32'h1, `SCEC_RESP_SLVERR);
    @(posedge aclk);
    st_lvl <= 1'h0;
    repeat (5) @(negedge aclk);
    chk(rx_serial_data, 1'h1);
    chk(port_rx_data, 1'h0);
    chk({tx_pin_o, tx_pin_oe_n}, 2'h3);
    wr(`SCEC_ADDR_CTRL, RXEN | TXEN);
    repeat (5) @(negedge aclk);
    chk({rx_enable, rx_serial_data, port_rx_data}, 3'h5);
    chk({tx_enable, tx_pin_o, tx_pin_oe_n}, 3'h4);
    @(posedge aclk);
    st_lvl <= 1'h1;
  endtask

  // Transmit requests gated by their enables; the line raised, masked, cleared.
  task automatic t_tx();
    @(posedge aclk);
    tx_end <= 1'h1;
    tx_data_empty <= 1'h1;
    repeat (3) @(negedge aclk);
    chk({tx_end_irq, tx_empty_irq}, 2'h0);
    wr(`SCEC_ADDR_CTRL, RXEN | TXEN | TEIE | TXIE);
    repeat (3) @(negedge aclk);
    chk({tx_end_irq, tx_empty_irq}, 2'h3);
    rd(`SCEC_ADDR_IRQ_STAT, EV_TE);
    wr(`SCEC_ADDR_IRQ_EN, EV_TE);
    repeat (3) @(negedge aclk);
    chk(irq, 1'h1);
    wr(`SCEC_ADDR_IRQ_EN, 32'h0);
    repeat (3) @(negedge aclk);
    chk(irq, 1'h0);
    wr(`SCEC_ADDR_IRQ_EN, EV_TE);
    wr(`SCEC_ADDR_IRQ_CLR, EV_TE);
    repeat (3) @(negedge aclk);
    chk(irq, 1'h0);
    rd(`SCEC_ADDR_IRQ_STAT, 32'h0);
    @(posedge aclk);
    tx_end <= 1'h0;
    tx_data_empty <= 1'h0;
    repeat (3) @(negedge aclk);
    chk({tx_end_irq, tx_empty_irq}, 2'h0);
  endtask

  // Normal reception, receive requests off and then on.
  task automatic t_rx();
    wr(`SCEC_ADDR_CTRL, RXEN);
    frame(1'h0, 1'h1);
    rd(`SCEC_ADDR_STATUS, 32'hb);
    chk({rx_full_irq, rx_error_irq}, 2'h0);
    wr(`SCEC_ADDR_CTRL, RXEN | RXIE);
    repeat (3) @(negedge aclk);
    chk({rx_full_irq, rx_error_irq}, 2'h3);
    frame(1'h0, 1'h0);
    rd(`SCEC_ADDR_STATUS, 32'hf);
    wr(`SCEC_ADDR_FLAG_CLR, 32'h7);
    wr(`SCEC_ADDR_IRQ_CLR, 32'hf);
    rd(`SCEC_ADDR_STATUS, 32'h8);
    // A frame that arrives while the clock enable is low leaves no trace.
    @(posedge aclk);
    ce <= 1'h0;
    frame(1'h0, 1'h1);
    ce <= 1'h1;
    rd(`SCEC_ADDR_STATUS, 32'h8);
    rd(`SCEC_ADDR_IRQ_STAT, 32'h0);
  endtask

  // Multiprocessor filtering up to and after the marked frame.
  task automatic t_mp();
    wr(`SCEC_ADDR_CTRL, RXEN | RXIE | MPIE);
    frame(1'h0, 1'h1);
    rd(`SCEC_ADDR_STATUS, 32'h8);
    rd(`SCEC_ADDR_IRQ_STAT, 32'h0);
    rd(`SCEC_ADDR_CTRL, RXEN | RXIE | MPIE);
    chk({rx_full_irq, rx_error_irq}, 2'h0);
    frame(1'h1, 1'h0);
    rd(`SCEC_ADDR_CTRL, RXEN | RXIE);
    rd(`SCEC_ADDR_STATUS, 32'h9);
    rd(`SCEC_ADDR_IRQ_STAT, 32'h9);
    chk(rx_full_irq, 1'h1);
    wr(`SCEC_ADDR_CTRL, RXEN | RXIE | MPIE);
    repeat (3) @(negedge aclk);
    chk(rx_full_irq, 1'h0);
    wr(`SCEC_ADDR_CTRL, 32'h0);
    wr(`SCEC_ADDR_FLAG_CLR, 32'h7);
    frame(1'h1, 1'h0);
    rd(`SCEC_ADDR_STATUS, 32'h8);
  endtask

  // Reset, then the scenarios in turn.
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    t_pins();
    t_tx();
    t_rx();
    t_mp();
    tally_and_finish();
  end
endmodule // serial_ctrl_enable_bits_bench
`default_nettype wire
